// File: rtl/ring_axi_slave.sv
// axi4-lite slave front end, one write and one read in flight
// assumes the owner answers register requests in the same cycle
`timescale 1ns/10ps
`include "ring_params.svh"

module ring_axi_slave (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // axi4-lite
    input  wire logic [`RV_ADDR_W-1:0] awaddr_i,
    input  wire logic                  awvalid_i,
    output logic                       awready_o,
    input  wire logic [31:0]           wdata_i,
    input  wire logic [3:0]            wstrb_i,
    input  wire logic                  wvalid_i,
    output logic                       wready_o,
    output logic [1:0]                 bresp_o,
    output logic                       bvalid_o,
    input  wire logic                  bready_i,
    input  wire logic [`RV_ADDR_W-1:0] araddr_i,
    input  wire logic                  arvalid_i,
    output logic                       arready_o,
    output logic [31:0]                rdata_o,
    output logic [1:0]                 rresp_o,
    output logic                       rvalid_o,
    input  wire logic                  rready_i,
    // register side
    output logic                       wr_req_o,
    output logic [`RV_ADDR_W-1:0]      wr_addr_o,
    output logic [31:0]                wr_data_o,
    output logic [3:0]                 wr_strb_o,
    input  wire logic                  wr_ok_i,
    output logic                       rd_req_o,
    output logic [`RV_ADDR_W-1:0]      rd_addr_o,
    input  wire logic [31:0]           rd_data_i,
    input  wire logic                  rd_ok_i
);

    ring_pkg::axi_regs_t q;
    ring_pkg::axi_regs_t n;

    // the write goes through only once both halves are held
    assign wr_req_o  = q.aw_held & q.w_held & ~q.bvalid;
    assign wr_addr_o = q.aw_addr;
    assign wr_data_o = q.w_data;
    assign wr_strb_o = q.w_strb;
    assign rd_req_o  = arvalid_i & q.arready;
    assign rd_addr_o = araddr_i;

    always_comb begin
        n = q;
        if (awvalid_i && q.awready) begin
            n.aw_held = 1'b1;
            n.aw_addr = awaddr_i;
        end
        if (wvalid_i && q.wready) begin
            n.w_held = 1'b1;
            n.w_data = wdata_i;
            n.w_strb = wstrb_i;
        end
        if (wr_req_o) begin
            n.bvalid  = 1'b1;
            n.bresp   = wr_ok_i ? `RV_RESP_OKAY : `RV_RESP_SLVERR;
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
        end else if (q.bvalid && bready_i) begin
            n.bvalid = 1'b0;
        end
        if (rd_req_o) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_ok_i ? rd_data_i : 32'h0;
            n.rresp  = rd_ok_i ? `RV_RESP_OKAY : `RV_RESP_SLVERR;
        end else if (q.rvalid && rready_i) begin
            n.rvalid = 1'b0;
        end
        // readies are registered so the top's outputs stay flop-driven
        n.awready = ~n.aw_held & ~n.bvalid;
        n.wready  = ~n.w_held & ~n.bvalid;
        n.arready = ~n.rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign awready_o = q.awready;
    assign wready_o  = q.wready;
    assign bvalid_o  = q.bvalid;
    assign bresp_o   = q.bresp;
    assign arready_o = q.arready;
    assign rvalid_o  = q.rvalid;
    assign rdata_o   = q.rdata;
    assign rresp_o   = q.rresp;

endmodule

// File: rtl/ring_params.svh
// ring qualifier constants: offsets, field positions, reset values, timing
// assumes a 200 MHz clock and 32-bit AXI4-Lite register access
`ifndef RING_PARAMS_SVH
`define RING_PARAMS_SVH

`define RV_ADDR_W        8
// register byte offsets
`define RV_CTRL_OFS      8'h00
`define RV_MINF_OFS      8'h04
`define RV_MAXF_OFS      8'h08
`define RV_STATUS_OFS    8'h0c
`define RV_IRQ_EN_OFS    8'h10
`define RV_IRQ_CLR_OFS   8'h14
`define RV_STATE_OFS     8'h18
// field positions
`define RV_ENABLE_BIT    7
`define RV_DELAY_HI      6
`define RV_DELAY_LO      4
`define RV_CONFIRM_HI    3
`define RV_CONFIRM_LO    1
// reset values
`define RV_CTRL_RST      8'h88
`define RV_MINF_RST      6'h19
`define RV_MAXF_RST      4'h6
// status bits
`define RV_ST_VALID      0
`define RV_ST_LOW        1
`define RV_ST_HIGH       2
// timing
`define RV_CLK_PERIOD_PS 5000
`define RV_TICK_MS       2
`define RV_DELAY_STEP_MS 256
// axi responses
`define RV_RESP_OKAY     2'b00
`define RV_RESP_SLVERR   2'b10

`endif

// File: rtl/ring_pkg.sv
// types shared by the ring qualifier modules
// assumes ring_params.svh supplies the widths
`include "ring_params.svh"

package ring_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CONFIRM = 2'b01,
        ST_DELAY   = 2'b10,
        ST_VALID   = 2'b11
    } ring_state_t;

    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    arready;
        logic                    aw_held;
        logic [`RV_ADDR_W-1:0]   aw_addr;
        logic                    w_held;
        logic [31:0]             w_data;
        logic [3:0]              w_strb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } axi_regs_t;

    typedef struct packed {
        ring_state_t state;
        logic [5:0]  timer;
        logic [9:0]  confirm_cnt;
        logic [9:0]  delay_cnt;
        logic        ring_valid;
        logic [2:0]  status;
        logic [2:0]  irq_en;
        logic        irq;
        logic [7:0]  ctrl;
        logic [5:0]  min_freq;
        logic [3:0]  max_freq;
    } ring_regs_t;

endpackage

// File: rtl/ring_tick.sv
// free-running timebase: one-cycle pulse every tick_cycles clocks
// assumes a synchronous active-high reset
`timescale 1ns/10ps

module ring_tick #(
    parameter int TICK_CYCLES = 400000
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // timebase
    output logic      tick_o
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tick_regs_t;

    tick_regs_t q;
    tick_regs_t n;

    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (q.cnt >= 32'(TICK_CYCLES - 1)) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = q.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick_o = q.tick;

endmodule

// File: rtl/ring_validation.sv
// ring qualifier: times tip/ring event spacing and reports a valid ring
// assumes tip_ring_event_i is a one-cycle synchronous pulse per crossing
`timescale 1ns/10ps
`include "ring_params.svh"

module ring_validation #(
    parameter int TICK_CYCLES = (`RV_TICK_MS * 1000000000) / `RV_CLK_PERIOD_PS
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // axi4-lite register port
    input  wire logic [`RV_ADDR_W-1:0] awaddr_i,
    input  wire logic                  awvalid_i,
    output logic                       awready_o,
    input  wire logic [31:0]           wdata_i,
    input  wire logic [3:0]            wstrb_i,
    input  wire logic                  wvalid_i,
    output logic                       wready_o,
    output logic [1:0]                 bresp_o,
    output logic                       bvalid_o,
    input  wire logic                  bready_i,
    input  wire logic [`RV_ADDR_W-1:0] araddr_i,
    input  wire logic                  arvalid_i,
    output logic                       arready_o,
    output logic [31:0]                rdata_o,
    output logic [1:0]                 rresp_o,
    output logic                       rvalid_o,
    input  wire logic                  rready_i,
    // line side
    input  wire logic                  tip_ring_event_i,
    // indications
    output logic                       ring_valid_o,
    output logic                       irq_o
);

    ring_pkg::ring_regs_t q;
    ring_pkg::ring_regs_t n;

    logic                  tick;
    logic                  wr_req;
    logic [`RV_ADDR_W-1:0] wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic                  wr_ok;
    logic                  rd_req;
    logic [`RV_ADDR_W-1:0] rd_addr;
    logic [31:0]           rd_data;
    logic                  rd_ok;
    logic                  enable;
    logic [2:0]            set_bits;
    logic [2:0]            clr_bits;

    // confirmation period in 2 ms ticks
    function automatic logic [9:0] confirm_ticks(input logic [2:0] code);
        logic [10:0] ms;
        ms = 11'd0;
        unique case (code)
            3'h0: ms = 11'd100;
            3'h1: ms = 11'd150;
            3'h2: ms = 11'd200;
            3'h3: ms = 11'd256;
            3'h4: ms = 11'd384;
            3'h5: ms = 11'd512;
            3'h6: ms = 11'd640;
            3'h7: ms = 11'd1024;
        endcase
        return 10'(ms / 11'(`RV_TICK_MS));
    endfunction

    // report delay in 2 ms ticks: code steps of 256 ms
    function automatic logic [9:0] delay_ticks(input logic [2:0] code);
        return 10'(code) * 10'(`RV_DELAY_STEP_MS / `RV_TICK_MS);
    endfunction

    // timebase shared by the interval timer and both counters
    ring_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .tick_o  (tick)
    );

    ring_axi_slave u_bus (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .awaddr_i  (awaddr_i),
        .awvalid_i (awvalid_i),
        .awready_o (awready_o),
        .wdata_i   (wdata_i),
        .wstrb_i   (wstrb_i),
        .wvalid_i  (wvalid_i),
        .wready_o  (wready_o),
        .bresp_o   (bresp_o),
        .bvalid_o  (bvalid_o),
        .bready_i  (bready_i),
        .araddr_i  (araddr_i),
        .arvalid_i (arvalid_i),
        .arready_o (arready_o),
        .rdata_o   (rdata_o),
        .rresp_o   (rresp_o),
        .rvalid_o  (rvalid_o),
        .rready_i  (rready_i),
        .wr_req_o  (wr_req),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .wr_strb_o (wr_strb),
        .wr_ok_i   (wr_ok),
        .rd_req_o  (rd_req),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data),
        .rd_ok_i   (rd_ok)
    );

    assign enable = q.ctrl[`RV_ENABLE_BIT];

    // register read decode
    always_comb begin
        rd_data = 32'h0;
        rd_ok   = 1'b1;
        unique case (rd_addr)
            `RV_CTRL_OFS:    rd_data = {24'h0, q.ctrl};
            `RV_MINF_OFS:    rd_data = {26'h0, q.min_freq};
            `RV_MAXF_OFS:    rd_data = {28'h0, q.max_freq};
            `RV_STATUS_OFS:  rd_data = {29'h0, q.status};
            `RV_IRQ_EN_OFS:  rd_data = {29'h0, q.irq_en};
            `RV_IRQ_CLR_OFS: rd_data = 32'h0;
            `RV_STATE_OFS:   rd_data = {18'h0, q.timer, 5'h0, q.ring_valid, q.state};
            default:         rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        wr_ok = 1'b1;
        unique case (wr_addr)
            `RV_CTRL_OFS, `RV_MINF_OFS, `RV_MAXF_OFS, `RV_STATUS_OFS,
            `RV_IRQ_EN_OFS, `RV_IRQ_CLR_OFS, `RV_STATE_OFS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        n        = q;
        set_bits = 3'h0;
        clr_bits = 3'h0;

        // register writes; only the low byte lane carries data
        if (wr_req && wr_strb[0]) begin
            unique case (wr_addr)
                // bit 0 is stored as written; software keeps it zero
                `RV_CTRL_OFS:    n.ctrl = wr_data[7:0];
                `RV_MINF_OFS:    n.min_freq = wr_data[5:0];
                `RV_MAXF_OFS:    n.max_freq = wr_data[3:0];
                `RV_IRQ_EN_OFS:  n.irq_en = wr_data[2:0];
                `RV_IRQ_CLR_OFS: clr_bits = wr_data[2:0];
                default:         n.ctrl = q.ctrl;
            endcase
        end

        if (!enable) begin
            // bypass: every event is passed straight on as a ring
            n.state       = ring_pkg::ST_IDLE;
            n.timer       = 6'h0;
            n.confirm_cnt = 10'h0;
            n.delay_cnt   = 10'h0;
            n.ring_valid  = tip_ring_event_i;
        end else begin
            unique case (q.state)
                ring_pkg::ST_IDLE: begin
                    n.ring_valid = 1'b0;
                    if (tip_ring_event_i) begin
                        n.timer       = q.min_freq;
                        n.confirm_cnt = confirm_ticks(q.ctrl[`RV_CONFIRM_HI:`RV_CONFIRM_LO]);
                        n.state       = ring_pkg::ST_CONFIRM;
                    end
                end
                ring_pkg::ST_CONFIRM, ring_pkg::ST_DELAY, ring_pkg::ST_VALID: begin
                    if (tip_ring_event_i && q.timer > 6'(q.max_freq)) begin
                        // events too close: restart confirmation
                        set_bits[`RV_ST_HIGH] = 1'b1;
                        n.timer       = q.min_freq;
                        n.ring_valid  = 1'b0;
                        n.confirm_cnt = confirm_ticks(q.ctrl[`RV_CONFIRM_HI:`RV_CONFIRM_LO]);
                        n.state       = ring_pkg::ST_CONFIRM;
                    end else if (!tip_ring_event_i && tick && q.timer <= 6'h1) begin
                        // the next event can only come late: too low
                        set_bits[`RV_ST_LOW] = 1'b1;
                        n.timer      = 6'h0;
                        n.ring_valid = 1'b0;
                        n.state      = ring_pkg::ST_IDLE;
                    end else begin
                        // an event must not swallow a tick, or every period stretches
                        if (tip_ring_event_i) begin
                            n.timer = q.min_freq;
                        end else if (tick) begin
                            n.timer = q.timer - 6'h1;
                        end
                        if (tick && q.state == ring_pkg::ST_CONFIRM) begin
                            if (q.confirm_cnt <= 10'h1) begin
                                n.delay_cnt = delay_ticks(q.ctrl[`RV_DELAY_HI:`RV_DELAY_LO]);
                                n.state     = ring_pkg::ST_DELAY;
                                if (n.delay_cnt == 10'h0) begin
                                    n.state      = ring_pkg::ST_VALID;
                                    n.ring_valid = 1'b1;
                                    set_bits[`RV_ST_VALID] = 1'b1;
                                end
                            end else begin
                                n.confirm_cnt = q.confirm_cnt - 10'h1;
                            end
                        end else if (tick && q.state == ring_pkg::ST_DELAY) begin
                            if (q.delay_cnt <= 10'h1) begin
                                n.state      = ring_pkg::ST_VALID;
                                n.ring_valid = 1'b1;
                                set_bits[`RV_ST_VALID] = 1'b1;
                            end else begin
                                n.delay_cnt = q.delay_cnt - 10'h1;
                            end
                        end
                    end
                end
            endcase
        end

        // a new event wins over a clear in the same cycle
        n.status = (q.status & ~clr_bits) | set_bits;
        n.irq    = |(n.status & n.irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q          <= '0;
            q.ctrl     <= `RV_CTRL_RST;
            q.min_freq <= `RV_MINF_RST;
            q.max_freq <= `RV_MAXF_RST;
        end else begin
            q <= n;
        end
    end

    assign ring_valid_o = q.ring_valid;
    assign irq_o        = q.irq;

endmodule

// File: tb/ring_line_model.sv
// line-side detector model: one-cycle event pulse every period_i clocks while run_i is high
// assumes period_i stays above 1 during a run
`timescale 1ns/10ps
module ring_line_model (
    // clock and control
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic [31:0] period_i,
    // line events
    output logic      event_o = 1'b0
);
    int cnt = 0;
    // the event line idles low between runs, as a quiet detector would
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt     <= 0;
            event_o <= 1'b0;
        end else begin
            event_o <= (cnt == 0);
            cnt     <= (cnt + 1 == period_i) ? 0 : cnt + 1;
        end
    end
endmodule

// File: tb/ring_validation_sva.sv
// checker for the ports of ring_validation
// assumes the bench offers write address and data in the same cycle
`timescale 1ns/10ps
`include "ring_params.svh"
module ring_validation_sva #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    // register bus
    input wire logic [`RV_ADDR_W-1:0] awaddr_i,
    input wire logic                  awvalid_i,
    input wire logic                  awready_o,
    input wire logic [31:0]           wdata_i,
    input wire logic                  wvalid_i,
    input wire logic                  wready_o,
    input wire logic [1:0]            bresp_o,
    input wire logic                  bvalid_o,
    input wire logic                  bready_i,
    input wire logic                  arvalid_i,
    input wire logic                  arready_o,
    input wire logic [31:0]           rdata_o,
    input wire logic                  rvalid_o,
    input wire logic                  rready_i,
    // line and indication
    input wire logic                  tip_ring_event_i,
    input wire logic                  ring_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic                  pend;
    logic [`RV_ADDR_W-1:0] p_addr;
    logic [31:0]           p_data;
    logic                  en_q;
    logic [5:0]            min_q;
    logic [15:0]           gap;

    // mirror of enable and minimum field, updated when the design applies a write
    always_ff @(posedge clk_i) begin
        p_addr <= awaddr_i;
        p_data <= wdata_i;
        if (reset_i) begin
            pend  <= 1'b0;
            en_q  <= 1'b1;
            min_q <= `RV_MINF_RST;
            gap   <= 16'h0000;
        end else begin
            pend <= awvalid_i && awready_o && wvalid_i && wready_o;
            if (pend && p_addr == `RV_CTRL_OFS) en_q <= p_data[`RV_ENABLE_BIT];
            if (pend && p_addr == `RV_MINF_OFS) min_q <= p_data[5:0];
            // saturating so a long quiet line never wraps back into range
            gap <= tip_ring_event_i ? 16'h0000 : ((gap == 16'hffff) ? gap : gap + 16'h0001);
        end
    end

    sequence wr_hs;
        awvalid_i && awready_o && wvalid_i && wready_o;
    endsequence
    sequence rd_hs;
        arvalid_i && arready_o;
    endsequence

    write_answer_a: assert property (wr_hs |-> ##2 bvalid_o)
        else $error("write response not on time");
    bresp_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped early");
    read_answer_a: assert property (rd_hs |=> rvalid_o)
        else $error("read data not on time");
    rdata_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data dropped early");
    aw_refuse_a: assert property (bvalid_o |-> !awready_o && !wready_o)
        else $error("write taken while response pending");
    ar_refuse_a: assert property (rvalid_o |-> !arready_o)
        else $error("read taken while data pending");
    bypass_copy_a: assert property (!en_q && !$past(en_q) |=> ring_valid_o == $past(tip_ring_event_i))
        else $error("bypass output not a copy of the event");
    too_low_drop_a: assert property (en_q && gap > (TICK_CYCLES * (int'(min_q) + 1) + 3) |-> !ring_valid_o)
        else $error("ring held after interval timer expiry");
endmodule

bind ring_validation ring_validation_sva #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .clk_i(clk_i), .reset_i(reset_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .tip_ring_event_i(tip_ring_event_i), .ring_valid_o(ring_valid_o));

// File: tb/tb_top.sv
// self-checking bench for ring_validation with a line-side event model
// assumes a 4-cycle tick so that one ms of ring time is two clocks
`timescale 1ns/10ps
`include "ring_params.svh"
module tb_top;
    localparam int TICK = 4;
    logic                  clk_i = 1'b0, reset_i = 1'b1;
    logic [`RV_ADDR_W-1:0] awaddr_i = '0, araddr_i = '0;
    logic [31:0]           wdata_i = '0, rdata_o;
    logic [3:0]            wstrb_i = 4'h0;
    logic                  awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
    logic                  arvalid_i = 1'b0, rready_i = 1'b0, run_i = 1'b0;
    logic                  awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic [1:0]            bresp_o, rresp_o;
    logic                  ev, ring_valid_o, irq_o;
    int                    period = 88;
    int                    n_errors = 0, checks_done = 0, cycles = 0;

    always #2.5 clk_i = ~clk_i;

    ring_line_model line (.clk_i(clk_i), .run_i(run_i), .period_i(period), .event_o(ev));
    ring_validation #(.TICK_CYCLES(TICK)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
        .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
        .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .tip_ring_event_i(ev), .ring_valid_o(ring_valid_o), .irq_o(irq_o));

    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // longest run is about 25k cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 60000) begin
            n_errors++;
            end_sim;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr_i <= a;
        wdata_i <= d;
        wstrb_i <= 4'hf;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awvalid_i && awready_o === 1'b1) begin
                awvalid_i <= 1'b0;
                aw_done = 1'b1;
            end
            if (wvalid_i && wready_o === 1'b1) begin
                wvalid_i <= 1'b0;
                w_done = 1'b1;
            end
        end while (!(aw_done && w_done));
        do @(posedge clk_i); while (bvalid_o !== 1'b1);
        // ready raised late so the response has to stand while unanswered
        bready_i <= 1'b1;
        @(posedge clk_i);
        chk({30'h0, bresp_o}, {30'h0, er}, "write response");
        bready_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        do @(posedge clk_i); while (arready_o !== 1'b1);
        arvalid_i <= 1'b0;
        do @(posedge clk_i); while (rvalid_o !== 1'b1);
        rready_i <= 1'b1;
        @(posedge clk_i);
        chk(rdata_o, e, "read data");
        chk({30'h0, rresp_o}, {30'h0, er}, "read response");
        rready_i <= 1'b0;
    endtask

    task test_regs;
        rd_chk(`RV_CTRL_OFS, 32'h88, `RV_RESP_OKAY);
        rd_chk(`RV_MINF_OFS, 32'h19, `RV_RESP_OKAY);
        wr_chk(`RV_MINF_OFS, 32'h19, `RV_RESP_OKAY); // 50 ms floor for 10 Hz
        rd_chk(`RV_MAXF_OFS, 32'h6, `RV_RESP_OKAY);
        rd_chk(`RV_STATUS_OFS, 32'h0, `RV_RESP_OKAY);
        rd_chk(8'h40, 32'h0, `RV_RESP_SLVERR);
        wr_chk(8'h40, 32'h5, `RV_RESP_SLVERR);
    endtask

    // confirm and report delay codes share the loop index; 88 clocks keeps spacing in range
    task automatic test_confirm_delay;
        int conf_ms[8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
        int n, exp;
        for (int i = 0; i < 8; i++) begin
            wr_chk(`RV_CTRL_OFS, {24'h0, 1'b1, 3'(i), 3'(i), 1'b0}, `RV_RESP_OKAY);
            exp = conf_ms[i] / `RV_TICK_MS * TICK + i * 128 * TICK;
            period = 88;
            run_i <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (ring_valid_o !== 1'b1);
            checks_done++;
            if (n < exp - 4 || n > exp + 12) begin
                n_errors++;
                $display("MISMATCH %0t valid ring after %0d cycles, expected %0d", $time, n, exp);
            end
            run_i <= 1'b0;
            repeat (160) @(posedge clk_i);
            chk({31'h0, ring_valid_o}, 32'h0, "ring kept after line went quiet");
            rd_chk(`RV_STATUS_OFS, 32'h3, `RV_RESP_OKAY);
            wr_chk(`RV_IRQ_CLR_OFS, 32'h7, `RV_RESP_OKAY);
        end
    endtask

    // events every 40 clocks leave too much on the timer at each crossing
    task test_too_high_irq;
        wr_chk(`RV_CTRL_OFS, 32'h80, `RV_RESP_OKAY);
        period = 40;
        run_i <= 1'b1;
        repeat (400) @(posedge clk_i);
        chk({31'h0, ring_valid_o}, 32'h0, "ring accepted above max frequency");
        run_i <= 1'b0;
        repeat (160) @(posedge clk_i);
        rd_chk(`RV_STATUS_OFS, 32'h6, `RV_RESP_OKAY);
        chk({31'h0, irq_o}, 32'h0, "masked interrupt raised");
        wr_chk(`RV_IRQ_EN_OFS, 32'h4, `RV_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1, "enabled interrupt missing");
        wr_chk(`RV_IRQ_CLR_OFS, 32'h4, `RV_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0, "interrupt kept after clear");
        rd_chk(`RV_STATUS_OFS, 32'h2, `RV_RESP_OKAY);
    endtask

    task test_bypass;
        wr_chk(`RV_CTRL_OFS, 32'h08, `RV_RESP_OKAY);
        period = 88;
        run_i <= 1'b1;
        do @(posedge clk_i); while (ev !== 1'b1);
        #1;
        chk({31'h0, ring_valid_o}, 32'h1, "bypass did not pass the event");
        @(posedge clk_i);
        #1;
        chk({31'h0, ring_valid_o}, 32'h0, "bypass output stretched");
        @(posedge clk_i);
        run_i <= 1'b0;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        test_regs;
        test_confirm_delay;
        test_too_high_irq;
        test_bypass;
        end_sim;
    end
endmodule
